// ===== rtl/irq_seq_pkg.sv
package irq_seq_pkg;

    // ==========================================================
    // Data memory addresses of the interrupt registers
    // ==========================================================
    localparam logic [7:0] ADDR_SOURCE_ENABLE_A   = 8'h50;
    localparam logic [7:0] ADDR_SOURCE_ENABLE_B   = 8'h51;
    localparam logic [7:0] ADDR_SOURCE_ENABLE_C   = 8'h52;
    localparam logic [7:0] ADDR_SOURCE_ENABLE_D   = 8'h53;
    localparam logic [7:0] ADDR_SOURCE_ENABLE_E   = 8'h54;
    localparam logic [7:0] ADDR_REQUEST_FLAGS_0   = 8'h55;
    localparam logic [7:0] ADDR_REQUEST_FLAGS_1   = 8'h56;
    localparam logic [7:0] ADDR_REQUEST_FLAGS_2   = 8'h57;
    localparam logic [7:0] ADDR_REQUEST_FLAGS_3   = 8'h58;
    localparam logic [7:0] ADDR_REQUEST_FLAGS_4   = 8'h59;
    localparam logic [7:0] ADDR_GLOBAL_ENABLE_REG = 8'hFF;

    // ==========================================================
    // Flattened request vector: bit = register * 4 + field bit
    // ==========================================================
    localparam int          NUM_SOURCES   = 20;
    localparam logic [19:0] REQ_IMPL_MASK = 20'hFCF97;
    localparam int          WATCHDOG_BIT  = 0;
    localparam logic [19:0] REQ_RESET     = 20'h00000;
    localparam logic [19:0] ENABLE_RESET  = 20'h00000;
    localparam logic        GLOBAL_EN_RESET = 1'b0;

    // ==========================================================
    // Program counter, vectors and call stack
    // ==========================================================
    localparam int          PC_W        = 16;
    localparam int          SP_W        = 4;
    localparam int          STACK_DEPTH = 16;
    localparam logic [15:0] VECTOR_BASE = 16'h0010;
    localparam logic [15:0] VECTOR_STEP = 16'h0002;
    localparam logic [3:0]  SP_RESET    = 4'h0;

    typedef enum logic [1:0] {
        ACT_IDLE   = 2'b00,
        ACT_ENTER  = 2'b01,
        ACT_RETURN = 2'b10
    } step_action_e;

    typedef struct packed {
        logic done;
        logic hold;
        logic enable_instr;
        logic disable_instr;
        logic normal_return_instr;
        logic nonmaskable_return_instr;
    } cpu_step_s;

    typedef struct packed {
        logic [3:0] port_b;
        logic [3:0] port_0;
        logic       melody_end_note;
        logic       watchdog_started;
        logic       watchdog_overflow;
        logic       port_e_pin_three;
        logic       tb_2hz;
        logic       tb_4hz;
        logic       tb_16hz;
        logic       tb_32hz;
        logic [3:0] timer_overflow;
        logic       carry_10hz;
        logic       shifter_done;
    } src_events_s;

endpackage

// ===== rtl/interrupt_request_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - Five 4-bit request registers; events set bits at next instruction start.
// - Maskable request reaches CPU only with global and source enable set.
// - Watchdog request is taken regardless of any enable bit.
// - Software writing 1 to a request bit creates a pending request.
// - Acceptance clears that request bit and global enable; source enables kept.
// - Reset clears all request bits.
// - External source 0 (register 0 bit 2) comes from OR of port B.
// - Melody end note sets register 0 bit 1.
// - Watchdog overflow after start sets register 0 bit 0.
// - External source 5 (register 1 bit 3) comes from OR of port 0.
// - Falling edge of 128 Hz/4 kHz tap on port E pin 3 sets register 1 bit 0.
// - Timer 0..3 overflows set register 2 bits 0..3.
// - 10 Hz carry sets register 3 bit 3.
// - Shift register transfer done sets register 3 bit 2.
// - Falling edges of 2, 4, 16, 32 Hz set register 4 bits 3..0.
// - Entry pushes PC, increments stack pointer, loads start address.
// - Entry adds no machine cycles.
// - Returns take one cycle: pointer minus one, PC from stack plus one.
// - Normal return sets global enable; non-maskable return restores it.
// - No acceptance right after a hold-class instruction.
// - Among pending requests the lowest start address wins.
// - Global enable resets to 0, read only, changed by instructions and entry.
module interrupt_request_sequencer (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    input  wire irq_seq_pkg::cpu_step_s  cpu_step,
    input  wire logic [15:0]             cpu_pc,
    input  wire irq_seq_pkg::src_events_s src_events,
    input  wire logic [7:0]              mem_addr,
    input  wire logic [3:0]              mem_wdata,
    input  wire logic                    mem_wr,
    input  wire logic                    mem_rd,
    output logic [3:0]                   mem_rdata,
    output logic                         pc_load,
    output logic [15:0]                  pc_value,
    output logic                         irq_accept,
    output logic [3:0]                   stack_ptr,
    output logic                         global_irq_enable
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [4:0] lowest_set(input logic [19:0] v);
        logic [4:0] idx;
        idx = 5'd0;
        for (int i = irq_seq_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // Start addresses grow with the flattened bit index
    function automatic logic [15:0] vector_of(input logic [4:0] idx);
        return irq_seq_pkg::VECTOR_BASE
             + 16'({11'h000, idx}) * irq_seq_pkg::VECTOR_STEP;
    endfunction

    function automatic logic [19:0] place4(input logic [19:0] cur,
                                           input int         grp,
                                           input logic [3:0] nib);
        logic [19:0] r;
        r = cur;
        r[grp*4 +: 4] = nib;
        return r;
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    logic [19:0] request_flags;
    logic [19:0] next_request_flags;
    logic [19:0] source_enable;
    logic [19:0] next_source_enable;
    logic [19:0] event_latch;
    logic [19:0] next_event_latch;
    logic        saved_enable;
    logic        next_saved_enable;
    logic        next_global_irq_enable;
    logic        prev_port_b_or;
    logic        prev_port_0_or;
    logic [4:0]  prev_taps;
    logic [3:0]  next_mem_rdata;
    logic        next_pc_load;
    logic [15:0] next_pc_value;
    logic        next_irq_accept;
    logic [3:0]  next_stack_ptr;
    logic [15:0] call_stack [0:irq_seq_pkg::STACK_DEPTH-1];
    logic        stack_we;

    logic [19:0] raw_events;
    logic [19:0] eligible;
    logic [4:0]  winner;
    logic        port_b_or;
    logic        port_0_or;
    logic [4:0]  taps;
    logic [3:0]  ret_sp;
    irq_seq_pkg::step_action_e action;

    // ==========================================================
    // Event sources
    // ==========================================================
    assign port_b_or = |src_events.port_b;
    assign port_0_or = |src_events.port_0;
    assign taps = {src_events.port_e_pin_three, src_events.tb_2hz,
                   src_events.tb_4hz, src_events.tb_16hz,
                   src_events.tb_32hz};

    always_comb begin
        raw_events = 20'h00000;
        raw_events[0] = src_events.watchdog_started
                      & src_events.watchdog_overflow;
        raw_events[1] = src_events.melody_end_note;
        raw_events[2] = port_b_or & ~prev_port_b_or;
        raw_events[4] = prev_taps[4] & ~taps[4];
        raw_events[7] = port_0_or & ~prev_port_0_or;
        raw_events[11:8] = src_events.timer_overflow;
        raw_events[14] = src_events.shifter_done;
        raw_events[15] = src_events.carry_10hz;
        raw_events[19:16] = prev_taps[3:0] & ~taps[3:0];
        raw_events = raw_events & irq_seq_pkg::REQ_IMPL_MASK;
    end

    // Events wait here until the next instruction begins
    always_comb begin
        next_event_latch = (cpu_step.done ? 20'h00000 : event_latch)
                         | raw_events;
    end

    // ==========================================================
    // Acceptance decision at an instruction boundary
    // ==========================================================
    always_comb begin
        eligible = request_flags & source_enable
                 & {20{global_irq_enable}};
        eligible[irq_seq_pkg::WATCHDOG_BIT] =
            request_flags[irq_seq_pkg::WATCHDOG_BIT];
        winner = lowest_set(eligible);
        ret_sp = stack_ptr - 4'h1;
        action = irq_seq_pkg::ACT_IDLE;
        if (cpu_step.done) begin
            if (cpu_step.normal_return_instr
                || cpu_step.nonmaskable_return_instr) begin
                action = irq_seq_pkg::ACT_RETURN;
            end else if (!cpu_step.hold && (|eligible)) begin
                action = irq_seq_pkg::ACT_ENTER;
            end
        end
    end

    // ==========================================================
    // Request, enable and global enable registers
    // ==========================================================
    always_comb begin
        next_request_flags     = request_flags;
        next_source_enable     = source_enable;
        next_global_irq_enable = global_irq_enable;
        next_saved_enable      = saved_enable;
        if (mem_wr) begin
            case (mem_addr)
                irq_seq_pkg::ADDR_SOURCE_ENABLE_A: begin
                    next_source_enable = place4(source_enable, 0, mem_wdata);
                end
                irq_seq_pkg::ADDR_SOURCE_ENABLE_B: begin
                    next_source_enable = place4(source_enable, 1, mem_wdata);
                end
                irq_seq_pkg::ADDR_SOURCE_ENABLE_C: begin
                    next_source_enable = place4(source_enable, 2, mem_wdata);
                end
                irq_seq_pkg::ADDR_SOURCE_ENABLE_D: begin
                    next_source_enable = place4(source_enable, 3, mem_wdata);
                end
                irq_seq_pkg::ADDR_SOURCE_ENABLE_E: begin
                    next_source_enable = place4(source_enable, 4, mem_wdata);
                end
                // Writing 1 pends, writing 0 withdraws
                irq_seq_pkg::ADDR_REQUEST_FLAGS_0: begin
                    next_request_flags = place4(request_flags, 0, mem_wdata);
                end
                irq_seq_pkg::ADDR_REQUEST_FLAGS_1: begin
                    next_request_flags = place4(request_flags, 1, mem_wdata);
                end
                irq_seq_pkg::ADDR_REQUEST_FLAGS_2: begin
                    next_request_flags = place4(request_flags, 2, mem_wdata);
                end
                irq_seq_pkg::ADDR_REQUEST_FLAGS_3: begin
                    next_request_flags = place4(request_flags, 3, mem_wdata);
                end
                irq_seq_pkg::ADDR_REQUEST_FLAGS_4: begin
                    next_request_flags = place4(request_flags, 4, mem_wdata);
                end
                default: begin
                end
            endcase
        end
        next_source_enable = next_source_enable & irq_seq_pkg::REQ_IMPL_MASK;
        if (cpu_step.done) begin
            if (cpu_step.enable_instr) begin
                next_global_irq_enable = 1'b1;
            end else if (cpu_step.disable_instr) begin
                next_global_irq_enable = 1'b0;
            end
        end
        case (action)
            irq_seq_pkg::ACT_ENTER: begin
                next_request_flags[winner] = 1'b0;
                next_global_irq_enable = 1'b0;
                if (winner == 5'(irq_seq_pkg::WATCHDOG_BIT)) begin
                    next_saved_enable = global_irq_enable;
                end
            end
            irq_seq_pkg::ACT_RETURN: begin
                next_global_irq_enable =
                    cpu_step.nonmaskable_return_instr
                    ? saved_enable : 1'b1;
            end
            default: begin
            end
        endcase
        // A hardware set wins over any clear in the same cycle
        if (cpu_step.done) begin
            next_request_flags = next_request_flags | event_latch;
        end
        next_request_flags = next_request_flags & irq_seq_pkg::REQ_IMPL_MASK;
    end

    // ==========================================================
    // Program counter, call stack and read data
    // ==========================================================
    always_comb begin
        next_pc_load    = 1'b0;
        next_pc_value   = pc_value;
        next_irq_accept = 1'b0;
        next_stack_ptr  = stack_ptr;
        stack_we        = 1'b0;
        case (action)
            // Vector goes out on the next edge, before the next fetch
            irq_seq_pkg::ACT_ENTER: begin
                stack_we        = 1'b1;
                next_stack_ptr  = stack_ptr + 4'h1;
                next_pc_value   = vector_of(winner);
                next_pc_load    = 1'b1;
                next_irq_accept = 1'b1;
            end
            irq_seq_pkg::ACT_RETURN: begin
                next_stack_ptr = ret_sp;
                next_pc_value  = call_stack[ret_sp] + 16'h0001;
                next_pc_load   = 1'b1;
            end
            default: begin
            end
        endcase
        next_mem_rdata = 4'h0;
        if (mem_rd) begin
            case (mem_addr)
                irq_seq_pkg::ADDR_SOURCE_ENABLE_A: next_mem_rdata = source_enable[3:0];
                irq_seq_pkg::ADDR_SOURCE_ENABLE_B: next_mem_rdata = source_enable[7:4];
                irq_seq_pkg::ADDR_SOURCE_ENABLE_C: next_mem_rdata = source_enable[11:8];
                irq_seq_pkg::ADDR_SOURCE_ENABLE_D: next_mem_rdata = source_enable[15:12];
                irq_seq_pkg::ADDR_SOURCE_ENABLE_E: next_mem_rdata = source_enable[19:16];
                irq_seq_pkg::ADDR_REQUEST_FLAGS_0: next_mem_rdata = request_flags[3:0];
                irq_seq_pkg::ADDR_REQUEST_FLAGS_1: next_mem_rdata = request_flags[7:4];
                irq_seq_pkg::ADDR_REQUEST_FLAGS_2: next_mem_rdata = request_flags[11:8];
                irq_seq_pkg::ADDR_REQUEST_FLAGS_3: next_mem_rdata = request_flags[15:12];
                irq_seq_pkg::ADDR_REQUEST_FLAGS_4: next_mem_rdata = request_flags[19:16];
                irq_seq_pkg::ADDR_GLOBAL_ENABLE_REG: begin
                    next_mem_rdata = {3'b000, global_irq_enable};
                end
                default: next_mem_rdata = 4'h0;
            endcase
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            request_flags     <= irq_seq_pkg::REQ_RESET;
            source_enable     <= irq_seq_pkg::ENABLE_RESET;
            event_latch       <= irq_seq_pkg::REQ_RESET;
            global_irq_enable <= irq_seq_pkg::GLOBAL_EN_RESET;
            saved_enable      <= irq_seq_pkg::GLOBAL_EN_RESET;
            prev_port_b_or    <= 1'b0;
            prev_port_0_or    <= 1'b0;
            prev_taps         <= 5'h00;
            mem_rdata         <= 4'h0;
            pc_load           <= 1'b0;
            pc_value          <= 16'h0000;
            irq_accept        <= 1'b0;
            stack_ptr         <= irq_seq_pkg::SP_RESET;
        end else if (clk_en) begin
            request_flags     <= next_request_flags;
            source_enable     <= next_source_enable;
            event_latch       <= next_event_latch;
            global_irq_enable <= next_global_irq_enable;
            saved_enable      <= next_saved_enable;
            prev_port_b_or    <= port_b_or;
            prev_port_0_or    <= port_0_or;
            prev_taps         <= taps;
            mem_rdata         <= next_mem_rdata;
            pc_load           <= next_pc_load;
            pc_value          <= next_pc_value;
            irq_accept        <= next_irq_accept;
            stack_ptr         <= next_stack_ptr;
        end
    end

    // Stack contents need no reset; the pointer guards them
    always_ff @(posedge sys_clk) begin
        if (clk_en && stack_we && !sys_rst) begin
            call_stack[stack_ptr] <= cpu_pc;
        end
    end

endmodule

// ===== dv/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire irq_seq_pkg::cpu_step_s cpu_step,
    input  wire logic                   pc_load,
    input  wire logic [15:0]            pc_value,
    output logic [15:0]                 cpu_pc
);
    logic [15:0] next_pc;

    // Load wins; the vector replaces the PC with no extra cycle
    always_comb begin
        next_pc = cpu_pc;
        if (pc_load)
            next_pc = pc_value;
        else if (cpu_step.done)
            next_pc = cpu_pc + 16'h0001;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            cpu_pc <= 16'h0100;
        else
            cpu_pc <= next_pc;
    end
endmodule

// ===== dv/irq_seq_checker.sv
`timescale 1ns/1ps
module irq_seq_checker (
    input wire logic                   sys_clk,
    input wire logic                   sys_rst,
    input wire logic                   clk_en,
    input wire irq_seq_pkg::cpu_step_s cpu_step,
    input wire logic [7:0]             mem_addr,
    input wire logic                   mem_rd,
    input wire logic [3:0]             mem_rdata,
    input wire logic                   pc_load,
    input wire logic [15:0]            pc_value,
    input wire logic                   irq_accept,
    input wire logic [3:0]             stack_ptr,
    input wire logic                   global_irq_enable
);
    logic step_ok;
    logic do_ret;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    assign step_ok = clk_en && cpu_step.done;
    assign do_ret  = step_ok && cpu_step.normal_return_instr;

    // ==========================================================
    // Entry, return and flag relations
    // ==========================================================
    a_reset_clear: assert property (disable iff (1'b0)
        sys_rst |=> stack_ptr == 4'h0 && !global_irq_enable && !pc_load)
        else $error("state not cleared by reset");
    a_accept_enable: assert property (
        irq_accept |-> pc_load && !global_irq_enable)
        else $error("entry left master enable set");
    a_accept_cause: assert property (
        irq_accept |-> $past(step_ok && !cpu_step.hold))
        else $error("entry without a non-hold step");
    a_hold_block: assert property (
        step_ok && cpu_step.hold ##1 1'b1 |-> !irq_accept)
        else $error("entry after a hold step");
    a_entry_push: assert property (
        irq_accept |-> stack_ptr == 4'($past(stack_ptr) + 4'h1))
        else $error("stack not pushed on entry");
    a_entry_vector: assert property (
        irq_accept |-> !pc_value[0] && pc_value >= 16'h0010
            && pc_value <= 16'h0036)
        else $error("entry vector out of range");
    a_return_pop: assert property (
        do_ret |=> pc_load && !irq_accept
            && stack_ptr == 4'($past(stack_ptr) - 4'h1))
        else $error("return did not pop in one cycle");
    a_return_enable: assert property (
        do_ret |=> global_irq_enable)
        else $error("return left master enable clear");
    a_disable_clears: assert property (
        step_ok && cpu_step.disable_instr |=> !global_irq_enable)
        else $error("disable left master enable set");
    a_enable_read: assert property (
        clk_en && mem_rd && mem_addr == 8'hFF
            |=> mem_rdata == {3'h0, $past(global_irq_enable)})
        else $error("master enable read mismatch");

    c_entry: cover property (irq_accept);
    c_nmi_ret: cover property (step_ok && cpu_step.nonmaskable_return_instr);
    c_enable_step: cover property (step_ok && cpu_step.enable_instr);
endmodule

bind interrupt_request_sequencer irq_seq_checker i_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cpu_step(cpu_step), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_value(pc_value),
    .irq_accept(irq_accept), .stack_ptr(stack_ptr),
    .global_irq_enable(global_irq_enable));

// ===== dv/interrupt_request_sequencer_tb.sv
`timescale 1ns/1ps
module interrupt_request_sequencer_tb;
    localparam logic [5:0]  S_RUN       = 6'h20;
    localparam logic [5:0]  S_HOLD      = 6'h30;
    localparam logic [5:0]  S_ENABLE    = 6'h38;
    localparam logic [5:0]  S_DISABLE   = 6'h34;
    localparam logic [5:0]  S_RETURN    = 6'h32;
    localparam logic [5:0]  S_NM_RETURN = 6'h31;
    localparam logic [19:0] M           = irq_seq_pkg::REQ_IMPL_MASK;
    localparam logic [7:0]  A_RQ        = irq_seq_pkg::ADDR_REQUEST_FLAGS_0;

    logic                     sys_clk;
    logic                     sys_rst;
    logic                     clk_en;
    irq_seq_pkg::cpu_step_s   cpu_step;
    irq_seq_pkg::src_events_s src_events;
    logic [15:0]              cpu_pc;
    logic [7:0]               mem_addr;
    logic [3:0]               mem_wdata;
    logic                     mem_wr;
    logic                     mem_rd;
    logic [3:0]               mem_rdata;
    logic                     pc_load;
    logic [15:0]              pc_value;
    logic                     irq_accept;
    logic [3:0]               stack_ptr;
    logic                     global_irq_enable;
    logic [15:0]              saved_pc;
    logic [19:0]              pend;
    int                       fails;
    int                       check_count;

    interrupt_request_sequencer i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .cpu_step(cpu_step), .cpu_pc(cpu_pc), .src_events(src_events),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .pc_load(pc_load),
        .pc_value(pc_value), .irq_accept(irq_accept),
        .stack_ptr(stack_ptr), .global_irq_enable(global_irq_enable));

    cpu_core_model i_cpu (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cpu_step(cpu_step),
        .pc_load(pc_load), .pc_value(pc_value), .cpu_pc(cpu_pc));

    always #20 sys_clk = ~sys_clk;

    // ==========================================================
    // Access tasks; wr, rd and step are entered 1 ns after a rising edge
    // ==========================================================
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    // Strobe drops for a full cycle so back-to-back calls stay clean
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1'b1;
        tick();
        mem_wr = 1'b0;
        tick();
    endtask

    task automatic rd(input logic [7:0] a, input logic [3:0] e);
        mem_addr = a;
        mem_rd = 1'b1;
        tick();
        mem_rd = 1'b0;
        chk(16'(mem_rdata), 16'(e));
        tick();
    endtask

    task automatic wregs(input logic [7:0] base, input logic [19:0] d);
        for (int g = 0; g < 5; g++)
            wr(base + 8'(g), d[4*g +: 4]);
    endtask

    task automatic flags(input logic [19:0] e);
        for (int g = 0; g < 5; g++)
            rd(A_RQ + 8'(g), e[4*g +: 4]);
    endtask

    task automatic step(input logic [5:0] s, input logic acc,
                        input logic ld, input logic [15:0] pv);
        if (acc)
            saved_pc = cpu_pc;
        cpu_step = s;
        tick();
        cpu_step = '0;
        chk(16'(irq_accept), 16'(acc));
        chk(16'(pc_load), 16'(ld));
        if (ld)
            chk(pc_value, pv);
        tick();
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        end_sim();
    end

    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        cpu_step = '0;
        src_events = '0;
        mem_addr = 8'h00;
        mem_wdata = 4'h0;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        saved_pc = 16'h0000;
        fails = 0;
        check_count = 0;
        repeat (3) tick();
        sys_rst = 1'b0;
        flags(20'h0);
        rd(8'hFF, 4'h0);
        wregs(A_RQ, 20'hFFFFF);
        flags(M);
        wregs(A_RQ, 20'h0);
        flags(20'h0);
        rd(8'h60, 4'h0);
        wr(8'hFF, 4'h1);
        rd(8'hFF, 4'h0);
        clk_en = 1'b0;
        wr(A_RQ, 4'h1);
        clk_en = 1'b1;
        flags(20'h0);
        // Overflow must be ignored until the watchdog runs
        src_events.watchdog_overflow = 1'b1;
        tick();
        src_events = '0;
        step(S_HOLD, 1'b0, 1'b0, 16'h0);
        flags(20'h0);
        // Whole-word drive: watchdog running, all five taps high
        src_events = 22'h0017C0;
        tick();
        // Taps fall; port ORs rise, overflow and every pulse fire
        src_events = 22'h20B83F;
        tick();
        src_events = '0;
        flags(20'h0);
        step(S_HOLD, 1'b0, 1'b0, 16'h0);
        flags(M);
        step(S_RUN, 1'b1, 1'b1, 16'h0010);
        chk(16'(stack_ptr), 16'h1);
        flags(M & 20'hFFFFE);
        step(S_NM_RETURN, 1'b0, 1'b1, saved_pc + 16'h1);
        chk(16'(stack_ptr), 16'h0);
        chk(16'(global_irq_enable), 16'h0);
        step(S_RUN, 1'b0, 1'b0, 16'h0);
        wregs(irq_seq_pkg::ADDR_SOURCE_ENABLE_A, 20'hFFFFF);
        step(S_RUN, 1'b0, 1'b0, 16'h0);
        step(S_ENABLE, 1'b0, 1'b0, 16'h0);
        step(S_HOLD, 1'b0, 1'b0, 16'h0);
        wr(A_RQ + 8'h4, 4'h7);
        pend = M & 20'h7FFFE;
        for (int b = 1; b < 20; b++)
            if (pend[b]) begin
                step(S_RUN, 1'b1, 1'b1, 16'h0010 + 16'(2 * b));
                chk(16'(global_irq_enable), 16'h0);
                step(S_RETURN, 1'b0, 1'b1, saved_pc + 16'h1);
                chk(16'(global_irq_enable), 16'h1);
            end
        step(S_RUN, 1'b0, 1'b0, 16'h0);
        rd(irq_seq_pkg::ADDR_SOURCE_ENABLE_C, 4'hF);
        step(S_DISABLE, 1'b0, 1'b0, 16'h0);
        rd(8'hFF, 4'h0);
        wr(A_RQ + 8'h2, 4'h2);
        step(S_RUN, 1'b0, 1'b0, 16'h0);
        step(S_ENABLE, 1'b0, 1'b0, 16'h0);
        // Watchdog outranks the pending timer; its return restores 1
        wr(A_RQ, 4'h1);
        step(S_RUN, 1'b1, 1'b1, 16'h0010);
        step(S_NM_RETURN, 1'b0, 1'b1, saved_pc + 16'h1);
        chk(16'(global_irq_enable), 16'h1);
        step(S_RUN, 1'b1, 1'b1, 16'h0022);
        wregs(A_RQ, 20'hFFFFF);
        sys_rst = 1'b1;
        repeat (3) tick();
        sys_rst = 1'b0;
        flags(20'h0);
        chk(16'(stack_ptr), 16'h0);
        end_sim();
    end
endmodule
